// >>> logic/cpusr_pkg.sv
/*
 cpusr_pkg: constants, types and field packing for the core status
 words, product path, multiplier operand register and hardware stack.
 Assumes one core clock shared by decoder, execution units and this block.
*/
// Function
// - product register: 32 bits, whole multiply result
// - product shifter: none, <<1, <<4, >>6, zero latency
// - stack: eight levels of 16-bit entries
// - 16-bit operand register feeds every multiply
// - operand register gives shift count, bit index
// - load/store status moves both words to memory
// - status load never changes interrupt mask
// - set/clear bit touches only one bit
// - reserved status bits always read one
// - word zero field layout fixed
// - word one field layout fixed
// - pointer write copies old pointer to buffer, except by status load
// - buffer load by status load also loads pointer
// - pointer written by addressing, pointer ops, load
// - carry: add carry=1, sub borrow=0
// - 16-bit shifted add only sets, sub only clears
// - carry also from shifts, bit ops, load
// - reset sets carry
// - map bit: 0 data space, 1 program space
// - map bit changed only by bit ops, load; reset 0
// - shift mode field picks product shifter action
// - interrupt mask set by reset and trap
package cpusr_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int PROD_W = 32;
   localparam int DATA_W = 16;
   localparam int STACK_LEVELS = 8;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int ST0_AP_LO = 13;
   localparam int ST0_OV = 12;
   localparam int ST0_OVM = 11;
   localparam int ST0_GLOBAL_IRQ_MASK = 9;
   localparam int ST1_AB_LO = 13;
   localparam int ST1_CNF = 12;
   localparam int ST1_TC = 11;
   localparam int ST1_SXM = 10;
   localparam int ST1_C = 9;
   localparam int ST1_XF = 4;
   localparam logic [15:0] ST0_RSV_MASK = 16'h0400;
   localparam logic [15:0] ST1_RSV_MASK = 16'h01EC;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RST_C = 1'h1;
   localparam logic RST_GLOBAL_IRQ_MASK = 1'h1;
   localparam logic RST_SXM = 1'h1;
   localparam logic RST_XF = 1'h1;
   localparam logic RST_CNF = 1'h0;
   localparam logic RST_FLAG = 1'h0;
   localparam logic [2:0] RST_PTR = 3'h0;
   localparam logic [8:0] RST_DP = 9'h000;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      PM_NONE = 2'b00, PM_L1 = 2'b01, PM_L4 = 2'b10, PM_R6 = 2'b11
   } cpusr_pm_t;
   typedef enum logic [2:0] {
      BIT_C = 3'b000, BIT_CNF = 3'b001, BIT_GLOBAL_IRQ_MASK = 3'b010, BIT_OVM = 3'b011,
      BIT_SXM = 3'b100, BIT_TC = 3'b101, BIT_XF = 3'b110
   } cpusr_bit_t;
   typedef enum logic [2:0] {
      CK_ADD = 3'b000, CK_SUB = 3'b001, CK_ADD16 = 3'b010, CK_SUB16 = 3'b011,
      CK_SHIFT = 3'b100
   } cpusr_ck_t;
   typedef struct packed {
      logic [2:0] ap;
      logic ov;
      logic overflow_saturate_mode;
      logic global_irq_mask;
      logic [8:0] dp;
      logic [2:0] ab;
      logic ram_map_select;
      logic tc;
      logic sign_extend_mode;
      logic c;
      logic xf;
      cpusr_pm_t pm;
   } cpusr_stat_t;
   typedef struct packed {
      logic valid;
      logic set;
      cpusr_bit_t sel;
   } cpusr_bitop_t;
   typedef struct packed {
      logic valid;
      cpusr_ck_t kind;
      logic flag; // carry out, borrow, or shifted-out bit
   } cpusr_carry_t;
   // ----------------------------------------
   // packing and shifting
   // ----------------------------------------
   function automatic logic [15:0] pack_st0(input cpusr_stat_t s);
      pack_st0 = {s.ap, s.ov, s.overflow_saturate_mode, 1'b1, s.global_irq_mask, s.dp};
   endfunction : pack_st0
   function automatic logic [15:0] pack_st1(input cpusr_stat_t s);
      pack_st1 = {s.ab, s.ram_map_select, s.tc, s.sign_extend_mode, s.c, 4'hF, s.xf, 2'h3, s.pm};
   endfunction : pack_st1
   function automatic logic [31:0] product_shifter(input logic [31:0] p, input cpusr_pm_t m);
      unique case (m)
         PM_NONE: product_shifter = p;
         PM_L1: product_shifter = {p[30:0], 1'b0};
         PM_L4: product_shifter = {p[27:0], 4'h0};
         PM_R6: product_shifter = {{6{p[31]}}, p[31:6]};
      endcase
   endfunction : product_shifter
endpackage : cpusr_pkg

// >>> logic/cpusr_regs.sv
/*
 cpusr_regs: status words, product register and shifter, multiplier
 operand register and eight-level hardware stack of the core.
 Assumes the decoder issues at most one status-writing operation per
 cycle; simultaneous requests resolve by the fixed priority below.
*/
`timescale 1ns/1ps
module cpusr_regs (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic MUL_VALID,
   input wire logic [31:0] MUL_RESULT,
   input wire logic OPND_WE,
   input wire logic [15:0] OPND_DATA,
   input wire logic LST0_WE,
   input wire logic LST1_WE,
   input wire logic [15:0] LST_DATA,
   input wire logic STORE_REQ,
   input wire logic STORE_SEL,
   input wire cpusr_pkg::cpusr_bitop_t BIT_OP,
   input wire cpusr_pkg::cpusr_carry_t CARRY_EVT,
   input wire logic AP_WE,
   input wire logic [2:0] AP_DATA,
   input wire logic OV_SET,
   input wire logic OV_CLR,
   input wire logic TC_WE,
   input wire logic TC_DATA,
   input wire logic DP_WE,
   input wire logic [8:0] DP_DATA,
   input wire logic PM_WE,
   input wire cpusr_pkg::cpusr_pm_t PM_DATA,
   input wire logic IRQ_TAKEN,
   input wire logic PUSH,
   input wire logic POP,
   input wire logic [15:0] PUSH_DATA,
   output cpusr_pkg::cpusr_stat_t STAT_Q,
   output logic [15:0] ST0_Q,
   output logic [15:0] ST1_Q,
   output logic [15:0] STORE_DATA,
   output logic STORE_VALID,
   output logic [31:0] PROD_Q,
   output logic [31:0] PROD_SCALED,
   output logic [15:0] OPERAND_Q,
   output logic [3:0] SHIFT_COUNT,
   output logic [3:0] BIT_INDEX,
   output logic [15:0] STACK_TOP
);
   import cpusr_pkg::*;

   cpusr_stat_t st_ff;
   cpusr_stat_t nxt_st;
   logic [15:0] st0_ff;
   logic [15:0] st1_ff;
   logic [15:0] store_ff;
   logic store_v_ff;
   logic [31:0] prod_ff;
   logic [31:0] nxt_prod;
   logic [31:0] scaled_ff;
   logic [15:0] opnd_ff;
   logic [15:0] stk_ff [STACK_LEVELS];

   // ----------------------------------------
   // status next value
   // ----------------------------------------
   // later assignments win: status load is applied last so a load
   // overrides same-cycle updates of the fields it loads
   always_comb begin
      nxt_st = st_ff;
      if (AP_WE) begin
         nxt_st.ab = st_ff.ap;
         nxt_st.ap = AP_DATA;
      end
      if (OV_SET)
         nxt_st.ov = 1'b1;
      else if (OV_CLR)
         nxt_st.ov = 1'b0;
      if (TC_WE)
         nxt_st.tc = TC_DATA;
      if (DP_WE)
         nxt_st.dp = DP_DATA;
      if (PM_WE)
         nxt_st.pm = PM_DATA;
      if (CARRY_EVT.valid) begin
         unique case (CARRY_EVT.kind)
            CK_ADD: nxt_st.c = CARRY_EVT.flag;
            CK_SUB: nxt_st.c = ~CARRY_EVT.flag;
            CK_ADD16: nxt_st.c = st_ff.c | CARRY_EVT.flag;
            CK_SUB16: nxt_st.c = st_ff.c & ~CARRY_EVT.flag;
            CK_SHIFT: nxt_st.c = CARRY_EVT.flag;
            default: nxt_st.c = st_ff.c;
         endcase
      end
      // single-bit set/clear, nothing else moves
      if (BIT_OP.valid) begin
         unique case (BIT_OP.sel)
            BIT_C: nxt_st.c = BIT_OP.set;
            BIT_CNF: nxt_st.ram_map_select = BIT_OP.set;
            BIT_GLOBAL_IRQ_MASK: nxt_st.global_irq_mask = BIT_OP.set;
            BIT_OVM: nxt_st.overflow_saturate_mode = BIT_OP.set;
            BIT_SXM: nxt_st.sign_extend_mode = BIT_OP.set;
            BIT_TC: nxt_st.tc = BIT_OP.set;
            BIT_XF: nxt_st.xf = BIT_OP.set;
            default: ; // unused select must not undo a same-cycle carry event
         endcase
      end
      // trap entry masks further maskable interrupts
      if (IRQ_TAKEN)
         nxt_st.global_irq_mask = 1'b1;
      // word zero load: mask bit kept, reserved bit dropped
      if (LST0_WE) begin
         nxt_st.ap = LST_DATA[ST0_AP_LO +: 3];
         nxt_st.ov = LST_DATA[ST0_OV];
         nxt_st.overflow_saturate_mode = LST_DATA[ST0_OVM];
         nxt_st.dp = LST_DATA[8:0];
      end
      // word one load: buffer also lands in pointer
      if (LST1_WE) begin
         nxt_st.ab = LST_DATA[ST1_AB_LO +: 3];
         nxt_st.ap = LST_DATA[ST1_AB_LO +: 3];
         nxt_st.ram_map_select = LST_DATA[ST1_CNF];
         nxt_st.tc = LST_DATA[ST1_TC];
         nxt_st.sign_extend_mode = LST_DATA[ST1_SXM];
         nxt_st.c = LST_DATA[ST1_C];
         nxt_st.xf = LST_DATA[ST1_XF];
         nxt_st.pm = cpusr_pm_t'(LST_DATA[1:0]);
      end
   end

   // ----------------------------------------
   // status registers
   // ----------------------------------------
   // words are repacked from the next value so reads track the fields
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         st_ff <= '{ap: RST_PTR, ov: RST_FLAG, overflow_saturate_mode: RST_FLAG, global_irq_mask: RST_GLOBAL_IRQ_MASK,
                    dp: RST_DP, ab: RST_PTR, ram_map_select: RST_CNF, tc: RST_FLAG,
                    sign_extend_mode: RST_SXM, c: RST_C, xf: RST_XF, pm: PM_NONE};
         st0_ff <= 16'h0600;
         st1_ff <= 16'h07FC;
      end else begin
         st_ff <= nxt_st;
         st0_ff <= pack_st0(nxt_st);
         st1_ff <= pack_st1(nxt_st);
      end
   end

   // ----------------------------------------
   // store status to memory
   // ----------------------------------------
   // stores the word as it stands before this cycle's updates
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         store_ff <= 16'h0000;
         store_v_ff <= 1'b0;
      end else begin
         store_v_ff <= STORE_REQ;
         if (STORE_REQ)
            store_ff <= STORE_SEL ? st1_ff : st0_ff;
      end
   end

   // ----------------------------------------
   // product register and shifter
   // ----------------------------------------
   assign nxt_prod = MUL_VALID ? MUL_RESULT : prod_ff;

   // scaled copy follows the register in the same edge, so no extra cycle
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         prod_ff <= 32'h00000000;
         scaled_ff <= 32'h00000000;
      end else begin
         prod_ff <= nxt_prod;
         scaled_ff <= product_shifter(nxt_prod, nxt_st.pm);
      end
   end

   // ----------------------------------------
   // multiplier operand register
   // ----------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RESETN)
         opnd_ff <= 16'h0000;
      else if (OPND_WE)
         opnd_ff <= OPND_DATA;
   end

   // ----------------------------------------
   // hardware stack
   // ----------------------------------------
   // shift-register stack: a ninth push loses the bottom entry and a
   // pop past the bottom repeats it, no overflow flag is kept
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < STACK_LEVELS; i++)
            stk_ff[i] <= 16'h0000;
      end else if (PUSH) begin
         stk_ff[0] <= PUSH_DATA;
         for (int i = 1; i < STACK_LEVELS; i++)
            stk_ff[i] <= stk_ff[i-1];
      end else if (POP) begin
         for (int i = 0; i < STACK_LEVELS - 1; i++)
            stk_ff[i] <= stk_ff[i+1];
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign STAT_Q = st_ff;
   assign ST0_Q = st0_ff;
   assign ST1_Q = st1_ff;
   assign STORE_DATA = store_ff;
   assign STORE_VALID = store_v_ff;
   assign PROD_Q = prod_ff;
   assign PROD_SCALED = scaled_ff;
   assign OPERAND_Q = opnd_ff;
   assign SHIFT_COUNT = opnd_ff[3:0];
   assign BIT_INDEX = opnd_ff[3:0];
   assign STACK_TOP = stk_ff[0];

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   AST_PROD_CAPTURE: assert property (MUL_VALID |=> PROD_Q == $past(MUL_RESULT))
      else $error("product not captured");
   AST_PROD_SCALE: assert property (PROD_SCALED == product_shifter(PROD_Q, STAT_Q.pm))
      else $error("scaled product mismatch");
   AST_STACK_POP: assert property (POP && !PUSH |=> STACK_TOP == $past(stk_ff[1]))
      else $error("pop did not lift stack");
   AST_OPND_LOAD: assert property (OPND_WE |=> OPERAND_Q == $past(OPND_DATA)
      && SHIFT_COUNT == $past(OPND_DATA[3:0]))
      else $error("operand register not loaded");
   AST_GLOBAL_IRQ_MASK_LST: assert property (LST0_WE && !BIT_OP.valid && !IRQ_TAKEN |=> $stable(STAT_Q.global_irq_mask))
      else $error("status load changed mask");
   AST_RSV_ONES: assert property ((ST0_Q & ST0_RSV_MASK) == ST0_RSV_MASK
      && (ST1_Q & ST1_RSV_MASK) == ST1_RSV_MASK)
      else $error("reserved bit reads zero");
   AST_PTR_BUF: assert property (AP_WE && !LST0_WE && !LST1_WE |=> STAT_Q.ab == $past(STAT_Q.ap))
      else $error("old pointer not buffered");
   AST_LST1_PTR: assert property (LST1_WE |=> STAT_Q.ap == STAT_Q.ab
      && ST1_Q[15:13] == $past(LST_DATA[15:13]))
      else $error("pointer not copied from buffer");
   AST_ADD16_C: assert property (CARRY_EVT.valid && CARRY_EVT.kind == CK_ADD16 && !BIT_OP.valid && !LST1_WE
      |=> STAT_Q.c >= $past(STAT_Q.c))
      else $error("shifted add cleared carry");
   AST_RESET_VAL: assert property ($rose(RESETN) |-> STAT_Q.c && !STAT_Q.ram_map_select && STAT_Q.global_irq_mask)
      else $error("bad reset status");
   AST_MAP_HOLD: assert property (!BIT_OP.valid && !LST1_WE |=> $stable(STAT_Q.ram_map_select))
      else $error("map bit changed");
   AST_IRQ_MASK: assert property (IRQ_TAKEN |=> STAT_Q.global_irq_mask && ST0_Q[ST0_GLOBAL_IRQ_MASK])
      else $error("trap did not mask");

   COV_PROD_R6: cover property (MUL_VALID && STAT_Q.pm == PM_R6);
   COV_LST1: cover property (LST1_WE ##1 STORE_REQ && STORE_SEL);
   COV_PUSH_POP: cover property (PUSH ##1 PUSH ##1 POP);
   COV_IRQ: cover property (IRQ_TAKEN && !STAT_Q.global_irq_mask);
endmodule : cpusr_regs

// >>> tb/cpusr_mul_model.sv
/*
 cpusr_mul_model: behavioural 16x16 signed multiplier standing in for the
 execution unit that feeds the product register.
 Assumes the shared core clock; one result per request, one cycle later.
*/
`timescale 1ns/1ps
module cpusr_mul_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] opa,
   input wire logic [15:0] opb,
   output logic valid,
   output logic [31:0] result
);
   // ----------------------------------------
   // multiply
   // ----------------------------------------
   // result holds only while valid; idle bus flips so a stray capture shows
   always_ff @(posedge clk) begin
      valid <= go;
      if (go) begin
         result <= $signed(opa) * $signed(opb);
      end else begin
         result <= ~result;
      end
   end
endmodule : cpusr_mul_model

// >>> tb/test_cpu_status_and_product_regs.sv
/*
 test_cpu_status_and_product_regs: random and corner stimulus for the
 status words, product path, operand register and stack.
 Assumes one op per cycle from the bench; a reference image of both words.
*/
`timescale 1ns/1ps
module test_cpu_status_and_product_regs;
   import cpusr_pkg::*;
   logic ref_clk, resetn, mul_valid, store_valid;
   logic [15:0] stb, din, st0_q, st1_q, store_data, operand_q, stack_top, opnd_exp, lfsr, r;
   logic [15:0] v [9];
   logic [31:0] mul_result, prod_q, prod_scaled, prod_exp, ew;
   logic [3:0] shift_count, bit_index;
   cpusr_stat_t stat_q;
   int n_errors, n_checks;

   cpusr_mul_model mul (.clk(ref_clk), .go(stb[7]), .opa(operand_q), .opb(din), .valid(mul_valid),
      .result(mul_result));
   cpusr_regs dut (.REF_CLK(ref_clk), .RESETN(resetn), .MUL_VALID(mul_valid), .MUL_RESULT(mul_result),
      .OPND_WE(stb[11]), .OPND_DATA(din), .LST0_WE(stb[0]), .LST1_WE(stb[1]), .LST_DATA(din),
      .STORE_REQ(stb[6]), .STORE_SEL(din[0]), .BIT_OP(cpusr_bitop_t'({stb[3], din[3:0]})),
      .CARRY_EVT(cpusr_carry_t'({stb[4], din[2:0], din[3]})), .AP_WE(stb[2]), .AP_DATA(din[2:0]),
      .OV_SET(stb[14]), .OV_CLR(stb[15]), .TC_WE(stb[13]), .TC_DATA(din[0]), .DP_WE(stb[12]),
      .DP_DATA(din[8:0]), .PM_WE(stb[8]), .PM_DATA(cpusr_pm_t'(din[1:0])), .IRQ_TAKEN(stb[5]),
      .PUSH(stb[9]), .POP(stb[10]), .PUSH_DATA(din), .STAT_Q(stat_q), .ST0_Q(st0_q), .ST1_Q(st1_q),
      .STORE_DATA(store_data), .STORE_VALID(store_valid), .PROD_Q(prod_q), .PROD_SCALED(prod_scaled),
      .OPERAND_Q(operand_q), .SHIFT_COUNT(shift_count), .BIT_INDEX(bit_index), .STACK_TOP(stack_top));

   // ----------------------------------------
   // expectation helpers
   // ----------------------------------------
   function automatic logic cnext(input logic [2:0] k, input logic f, input logic c);
      case (k)
         3'h0, 3'h4: cnext = f;
         3'h1: cnext = !f;
         3'h2: cnext = f | c; // shifted add may only set
         3'h3: cnext = c & !f; // shifted sub may only clear
         default: cnext = c;
      endcase
   endfunction : cnext
   // flat position in {word one, word zero}; -1 for the unused select
   function automatic int bpos(input logic [2:0] s);
      int t [8] = '{25, 28, 9, 11, 26, 27, 20, -1};
      bpos = t[s];
   endfunction : bpos
   function automatic logic [31:0] scale(input logic [31:0] p, input logic [1:0] m);
      case (m)
         2'h0: scale = p;
         2'h1: scale = p << 1;
         2'h2: scale = p << 4;
         default: scale = $signed(p) >>> 6;
      endcase
   endfunction : scale
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rnd = lfsr;
   endfunction : rnd

   // ----------------------------------------
   // checking and ending
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      if (n_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic look(input int k);
      chk(st0_q, ew[15:0]);
      chk(st1_q, ew[31:16]);
      chk(stat_q.ram_map_select, ew[28]);
      chk(store_valid, k == 6);
      chk(prod_q, prod_exp);
      chk(prod_scaled, scale(prod_exp, ew[17:16]));
      chk({operand_q, shift_count, bit_index}, {opnd_exp, opnd_exp[3:0], opnd_exp[3:0]});
   endtask : look
   // one strobe for a cycle, then update the reference image and compare
   task automatic fire(input int k, input logic [15:0] d);
      @(posedge ref_clk);
      stb <= 16'h0001 << k;
      din <= d;
      @(posedge ref_clk);
      stb <= '0;
      if (k == 7) @(posedge ref_clk);
      @(negedge ref_clk);
      case (k)
         0: ew[15:0] = (d & 16'hFDFF) | (ew[15:0] & 16'h0200) | 16'h0400;
         1: ew = {d[15:13], d[12:0] | 13'h01EC, d[15:13], ew[12:0]};
         2: ew = {ew[15:13], ew[28:16], d[2:0], ew[12:0]};
         3: if (bpos(d[2:0]) >= 0) ew[bpos(d[2:0])] = d[3];
         4: ew[25] = cnext(d[2:0], d[3], ew[25]);
         5: ew[9] = 1'b1;
         6: chk(store_data, d[0] ? ew[31:16] : ew[15:0]);
         7: prod_exp = $signed(opnd_exp) * $signed(d);
         8: ew[17:16] = d[1:0];
         11: opnd_exp = d;
         12: ew[8:0] = d[8:0];
         13: ew[27] = d[0];
         14: ew[12] = 1'b1;
         15: ew[12] = 1'b0;
         default: ;
      endcase
      look(k);
   endtask : fire

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // about 870 cycles expected; generous margin before giving up
   initial begin
      repeat (6000) @(posedge ref_clk);
      n_errors++;
      close_out();
   end
   initial begin
      resetn = 1'b0;
      stb = '0;
      din = '0;
      lfsr = 16'h002C;
      n_errors = 0;
      n_checks = 0;
      ew = {16'h07FC, 16'h0600};
      prod_exp = '0;
      opnd_exp = '0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      look(-1);
      for (int i = 0; i < 16; i++) fire(3, i[15:0]);
      for (int i = 0; i < 32; i++) begin
         fire(3, {12'h000, i[4], 3'h0});
         fire(4, {12'h000, i[3:0]});
      end
      fire(3, 16'h0002);
      fire(0, 16'hFFFF);
      fire(5, 16'h0000);
      fire(0, 16'h0000);
      fire(2, 16'h0005);
      fire(2, 16'h0003);
      fire(1, 16'hA000);
      fire(6, 16'h0000);
      fire(6, 16'h0001);
      fire(11, 16'h8000);
      fire(7, 16'h8000);
      for (int i = 0; i < 4; i++) begin
         fire(11, rnd());
         fire(8, i[15:0]);
         fire(7, rnd());
      end
      for (int i = 0; i < 9; i++) begin
         v[i] = rnd();
         fire(9, v[i]);
         chk(stack_top, v[i]);
      end
      for (int i = 7; i > 0; i--) begin
         fire(10, 16'h0000);
         chk(stack_top, v[i]);
      end
      repeat (300) begin
         r = rnd();
         fire(int'(r[3:0]), rnd());
      end
      close_out();
   end
endmodule : test_cpu_status_and_product_regs
